// *** dsp_map.svh ***
// Named constants of the dust sensor I2C command port.
// Assumes nothing; included by the package and the design files.
`ifndef DSP_MAP_SVH
`define DSP_MAP_SVH

// Command locations
`define DSP_LOC_FRAME 8'h00
`define DSP_LOC_POWER 8'h50
`define DSP_LOC_CLEAN 8'h51
`define DSP_LOC_SRESET 8'h52
`define DSP_LOC_DEPTH 8'h53
`define DSP_LOC_INTERVAL 8'h58
`define DSP_LOC_PRERUN 8'h59
`define DSP_LOC_PERIOD_HI 8'h5A
`define DSP_LOC_PERIOD_LO 8'h5B
`define DSP_LOC_DURATION 8'h5C
`define DSP_LOC_FAN_SPEED 8'h63

// Field positions and command codes
`define DSP_WAKE_BIT 7
`define DSP_NEWDATA_BIT 0
`define DSP_CLEAN_BIT 0
`define DSP_SRESET_CODE 8'h81

// Reset values
`define DSP_AWAKE_DEF 1'b1
`define DSP_DEPTH_DEF 8'h0A
`define DSP_INTERVAL_DEF 8'h00
`define DSP_PRERUN_DEF 8'h03
`define DSP_PERIOD_DEF 16'hEC40
`define DSP_DURATION_DEF 8'h0A
`define DSP_SPEED_DEF 8'h64

// Accepted ranges
`define DSP_RANGE_ZERO 8'h00
`define DSP_DEPTH_MIN 8'h01
`define DSP_DEPTH_MAX 8'h3C
`define DSP_INTERVAL_MAX 8'h3B
`define DSP_PRERUN_MAX 8'h3B
`define DSP_DURATION_MAX 8'h3C
`define DSP_SPEED_MIN 8'h3C
`define DSP_SPEED_MAX 8'h64

// Frame layout
`define DSP_FRAME_WORDS 12
`define DSP_VALUE_WORDS 11
`define DSP_STATUS_WORD 5
`define DSP_FLAG_BITS 3
`define DSP_POS_LO 3'h3
`define DSP_POS_LAST 3'h5
`define DSP_BYTE_BITS 4'h8

// Checksum
`define DSP_CRC_POLY 8'h31
`define DSP_CRC_INIT 8'hFF

// Timing
`define DSP_CLK_HZ 200000000
`define DSP_SEC_PER_TICK 1

`endif

// *** dsp_pkg.sv ***
// Types shared by the dust sensor I2C command port.
// Assumes dsp_map.svh is on the include path.
`include "dsp_map.svh"
`default_nettype none

package dsp_pkg;

	typedef enum logic [2:0] {
		DSP_IDLE = 3'h0,
		DSP_ADDR = 3'h1,
		DSP_ADDR_ACK = 3'h3,
		DSP_RX = 3'h2,
		DSP_RX_ACK = 3'h6,
		DSP_TX = 3'h7,
		DSP_TX_ACK = 3'h5
	} dsp_state_t;

	typedef struct packed {
		logic [`DSP_VALUE_WORDS-1:0][31:0] value;
		logic [`DSP_FLAG_BITS-1:0] flags;
	} dsp_meas_t;

	typedef struct packed {
		logic awake;
		logic [7:0] moving_average_depth;
		logic [7:0] measure_interval;
		logic [7:0] fan_prerun_time;
		logic [15:0] cleaning_period;
		logic [7:0] cleaning_duration;
		logic [7:0] fan_speed_percent;
	} dsp_cfg_t;

endpackage

`default_nettype wire

// *** dsp_crc8.sv ***
// Checksum of one 16-bit half of an output word.
// Assumes the caller presents the two bytes in sending order.
`include "dsp_map.svh"
`timescale 1ns/10ps
`default_nettype none

module dsp_crc8 (
	// Data pair, first byte in the high half
	input wire logic [15:0] data,
	// Checksum byte
	output logic [7:0] crc
);

	logic [7:0] acc;
	logic fb;

	always_comb
	begin
		acc = `DSP_CRC_INIT;
		fb = 1'b0;
		for (int i = 15; i >= 0; i--)
		begin
			fb = acc[7] ^ data[i];
			acc = {acc[6:0], 1'b0};
			if (fb)
				acc = acc ^ `DSP_CRC_POLY;
		end
		crc = acc;
	end

endmodule // dsp_crc8

`default_nettype wire

// *** dsp_i2c_port.sv ***
// I2C target command port of the dust sensor: frame readout and settings.
// Assumes SCL and SDA arrive unsynchronised from pins with external pull-ups,
// and that the sensor core presents results with a one-cycle valid pulse.
// How it works
// - Each 32-bit word goes out as upper half, checksum, lower half, checksum.
// - Each checksum covers only the two data bytes just before it, reads only.
// - Checksum is CRC-8, polynomial 0x31, start 0xFF, MSB first, no xor.
// - Location 0x00 is read only and returns the measurement frame.
// - Bit 7 at 0x50 writes wake or sleep and reads the wake state.
// - Bit 0 at 0x50 reads one while an unread result is waiting.
// - Writing 0x81 to 0x52 resets settings, cleaning and the new-data flag, not the pointer.
// - Location 0x53 holds moving-average depth 1 to 60, default 10.
// - Location 0x58 holds measure interval 0 to 59 seconds, default 0.
// - Location 0x59 holds fan pre-run 0 to 59 seconds, default 3.
// - Cleaning period, default 60480, high byte 0x5A, low byte 0x5B.
// - Bit 0 written at 0x51 starts cleaning for the 0x5C time.
// - Location 0x63 holds fan speed 60 to 100 percent, default 100.
// - Frame is twelve big-endian words, checksum ending at byte 71.
// - Status word bits 0..2 flag concentration, dust and fan faults.
`include "dsp_map.svh"
`timescale 1ns/10ps
`default_nettype none

module dsp_i2c_port #(
	parameter logic [6:0] TARGET_ADDR = 7'h28,
	parameter int TICKS_PER_SEC = `DSP_CLK_HZ * `DSP_SEC_PER_TICK
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// I2C pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Measurement results from the sensor core
	input wire dsp_pkg::dsp_meas_t meas,
	input wire logic meas_valid,
	// Settings and commands to the sensor core
	output var dsp_pkg::dsp_cfg_t cfg,
	output logic clean_start,
	output logic cleaning_busy,
	output logic soft_reset
);

	function automatic dsp_pkg::dsp_cfg_t cfg_default();
		dsp_pkg::dsp_cfg_t c;
		c.awake = `DSP_AWAKE_DEF;
		c.moving_average_depth = `DSP_DEPTH_DEF;
		c.measure_interval = `DSP_INTERVAL_DEF;
		c.fan_prerun_time = `DSP_PRERUN_DEF;
		c.cleaning_period = `DSP_PERIOD_DEF;
		c.cleaning_duration = `DSP_DURATION_DEF;
		c.fan_speed_percent = `DSP_SPEED_DEF;
		return c;
	endfunction

	function automatic logic in_range(input logic [7:0] v, input logic [7:0] lo,
		input logic [7:0] hi);
		return (v >= lo) && (v <= hi);
	endfunction

	logic scl_meta, scl_sync, scl_prev;
	logic sda_meta, sda_sync, sda_prev;
	logic scl_rise, scl_fall, bus_start, bus_stop;
	dsp_pkg::dsp_state_t state;
	logic [3:0] bit_cnt;
	logic [7:0] rx_shift;
	logic [7:0] tx_shift;
	logic is_read;
	logic first_byte;
	logic master_ack;
	logic [7:0] pointer;
	logic wr_strobe;
	logic addr_match;
	logic tx_load;
	logic frame_load;
	logic [7:0] next_tx_byte;
	logic new_data;
	logic [31:0] frame_words [0:`DSP_FRAME_WORDS-1];
	logic [31:0] snap [0:`DSP_FRAME_WORDS-1];
	logic [3:0] word_idx;
	logic [2:0] byte_pos;
	logic [31:0] cur_word;
	logic [15:0] cur_half;
	logic [7:0] cur_crc;
	logic [7:0] frame_byte;
	logic [31:0] sec_cnt;
	logic sec_tick;
	logic [7:0] clean_left;

	// Pin synchronisers; only the second and third stages are looked at
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			scl_meta <= 1'b1;
			scl_sync <= 1'b1;
			scl_prev <= 1'b1;
			sda_meta <= 1'b1;
			sda_sync <= 1'b1;
			sda_prev <= 1'b1;
		end
		else
		begin
			scl_meta <= scl_in;
			scl_sync <= scl_meta;
			scl_prev <= scl_sync;
			sda_meta <= sda_in;
			sda_sync <= sda_meta;
			sda_prev <= sda_sync;
		end
	end

	assign scl_rise = scl_sync && !scl_prev;
	assign scl_fall = !scl_sync && scl_prev;
	assign bus_start = scl_sync && scl_prev && sda_prev && !sda_sync;
	assign bus_stop = scl_sync && scl_prev && !sda_prev && sda_sync;

	// Open drain: only ever pulls low
	assign sda_out = 1'b0;

	assign addr_match = (state == dsp_pkg::DSP_ADDR) && scl_fall
		&& (bit_cnt == `DSP_BYTE_BITS) && (rx_shift[7:1] == TARGET_ADDR);
	assign wr_strobe = (state == dsp_pkg::DSP_RX) && scl_fall
		&& (bit_cnt == `DSP_BYTE_BITS);
	assign frame_load = addr_match && rx_shift[0] && (pointer == `DSP_LOC_FRAME);
	assign tx_load = (scl_fall && (state == dsp_pkg::DSP_ADDR_ACK) && is_read)
		|| (scl_fall && (state == dsp_pkg::DSP_TX_ACK) && master_ack);

	// Bus protocol engine
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state <= dsp_pkg::DSP_IDLE;
			bit_cnt <= 4'h0;
			rx_shift <= 8'h00;
			tx_shift <= 8'h00;
			is_read <= 1'b0;
			master_ack <= 1'b0;
			sda_oe <= 1'b0;
		end
		else if (bus_start)
		begin
			state <= dsp_pkg::DSP_ADDR;
			bit_cnt <= 4'h0;
			sda_oe <= 1'b0;
		end
		else if (bus_stop)
		begin
			state <= dsp_pkg::DSP_IDLE;
			sda_oe <= 1'b0;
		end
		else
		begin
			case (state)
				dsp_pkg::DSP_ADDR:
				begin
					if (scl_rise)
					begin
						rx_shift <= {rx_shift[6:0], sda_sync};
						bit_cnt <= bit_cnt + 4'h1;
					end
					else if (scl_fall && (bit_cnt == `DSP_BYTE_BITS))
					begin
						if (addr_match)
						begin
							state <= dsp_pkg::DSP_ADDR_ACK;
							is_read <= rx_shift[0];
							sda_oe <= 1'b1;
						end
						else
							state <= dsp_pkg::DSP_IDLE;
					end
				end
				dsp_pkg::DSP_ADDR_ACK:
				begin
					if (scl_fall)
					begin
						bit_cnt <= 4'h0;
						if (is_read)
						begin
							state <= dsp_pkg::DSP_TX;
							tx_shift <= next_tx_byte;
							sda_oe <= !next_tx_byte[7];
							bit_cnt <= 4'h1;
						end
						else
						begin
							state <= dsp_pkg::DSP_RX;
							sda_oe <= 1'b0;
						end
					end
				end
				dsp_pkg::DSP_RX:
				begin
					if (scl_rise)
					begin
						rx_shift <= {rx_shift[6:0], sda_sync};
						bit_cnt <= bit_cnt + 4'h1;
					end
					else if (wr_strobe)
					begin
						state <= dsp_pkg::DSP_RX_ACK;
						sda_oe <= 1'b1;
						bit_cnt <= 4'h0;
					end
				end
				dsp_pkg::DSP_RX_ACK:
				begin
					if (scl_fall)
					begin
						state <= dsp_pkg::DSP_RX;
						sda_oe <= 1'b0;
					end
				end
				dsp_pkg::DSP_TX:
				begin
					if (scl_fall)
					begin
						if (bit_cnt == `DSP_BYTE_BITS)
						begin
							state <= dsp_pkg::DSP_TX_ACK;
							sda_oe <= 1'b0;
						end
						else
						begin
							tx_shift <= {tx_shift[6:0], 1'b0};
							sda_oe <= !tx_shift[6];
							bit_cnt <= bit_cnt + 4'h1;
						end
					end
				end
				dsp_pkg::DSP_TX_ACK:
				begin
					if (scl_rise)
						master_ack <= !sda_sync;
					else if (scl_fall)
					begin
						if (master_ack)
						begin
							state <= dsp_pkg::DSP_TX;
							tx_shift <= next_tx_byte;
							sda_oe <= !next_tx_byte[7];
							bit_cnt <= 4'h1;
						end
						else
							state <= dsp_pkg::DSP_IDLE;
					end
				end
				default:
					state <= dsp_pkg::DSP_IDLE;
			endcase
		end
	end

	// Command location pointer: first written byte after the address
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pointer <= `DSP_LOC_FRAME;
			first_byte <= 1'b0;
		end
		else if (addr_match)
			first_byte <= !rx_shift[0];
		else if (wr_strobe && first_byte)
		begin
			pointer <= rx_shift;
			first_byte <= 1'b0;
		end
	end

	// Settings; out-of-range values are dropped, not clipped
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			cfg <= cfg_default();
		else if (soft_reset)
			cfg <= cfg_default();
		else if (wr_strobe && !first_byte)
		begin
			case (pointer)
				`DSP_LOC_POWER:
					cfg.awake <= rx_shift[`DSP_WAKE_BIT];
				`DSP_LOC_DEPTH:
					if (in_range(rx_shift, `DSP_DEPTH_MIN, `DSP_DEPTH_MAX))
						cfg.moving_average_depth <= rx_shift;
				`DSP_LOC_INTERVAL:
					if (in_range(rx_shift, `DSP_RANGE_ZERO, `DSP_INTERVAL_MAX))
						cfg.measure_interval <= rx_shift;
				`DSP_LOC_PRERUN:
					if (in_range(rx_shift, `DSP_RANGE_ZERO, `DSP_PRERUN_MAX))
						cfg.fan_prerun_time <= rx_shift;
				`DSP_LOC_PERIOD_HI:
					cfg.cleaning_period[15:8] <= rx_shift;
				`DSP_LOC_PERIOD_LO:
					cfg.cleaning_period[7:0] <= rx_shift;
				`DSP_LOC_DURATION:
					if (in_range(rx_shift, `DSP_RANGE_ZERO, `DSP_DURATION_MAX))
						cfg.cleaning_duration <= rx_shift;
				`DSP_LOC_FAN_SPEED:
					if (in_range(rx_shift, `DSP_SPEED_MIN, `DSP_SPEED_MAX))
						cfg.fan_speed_percent <= rx_shift;
				default:
					cfg <= cfg;
			endcase
		end
	end

	// Command pulses
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			soft_reset <= 1'b0;
			clean_start <= 1'b0;
		end
		else
		begin
			soft_reset <= wr_strobe && !first_byte && (pointer == `DSP_LOC_SRESET)
				&& (rx_shift == `DSP_SRESET_CODE);
			clean_start <= wr_strobe && !first_byte && (pointer == `DSP_LOC_CLEAN)
				&& rx_shift[`DSP_CLEAN_BIT];
		end
	end

	// One-second enable for the cleaning run timer
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sec_cnt <= 32'h0;
			sec_tick <= 1'b0;
		end
		else if (sec_cnt == 32'(TICKS_PER_SEC - 1))
		begin
			sec_cnt <= 32'h0;
			sec_tick <= 1'b1;
		end
		else
		begin
			sec_cnt <= sec_cnt + 32'h1;
			sec_tick <= 1'b0;
		end
	end

	// Cleaning run lasts the stored duration in seconds
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			clean_left <= 8'h00;
		else if (soft_reset)
			clean_left <= 8'h00;
		else if (clean_start)
			clean_left <= cfg.cleaning_duration;
		else if (sec_tick && (clean_left != 8'h00))
			clean_left <= clean_left - 8'h01;
	end

	assign cleaning_busy = (clean_left != 8'h00);

	// New result flag; a result in the clearing cycle wins
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			new_data <= 1'b0;
		else if (meas_valid)
			new_data <= 1'b1;
		else if (frame_load || soft_reset)
			new_data <= 1'b0;
	end

	// Frame words in sending order, status word in its slot
	always_comb
	begin
		for (int k = 0; k < `DSP_FRAME_WORDS; k++)
		begin
			if (k < `DSP_STATUS_WORD)
				frame_words[k] = meas.value[k];
			else if (k == `DSP_STATUS_WORD)
				frame_words[k] = {29'h0, meas.flags};
			else
				frame_words[k] = meas.value[k-1];
		end
	end

	// Snapshot at read start so one frame never mixes two results
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (int k = 0; k < `DSP_FRAME_WORDS; k++)
				snap[k] <= 32'h0;
		end
		else if (frame_load)
		begin
			for (int k = 0; k < `DSP_FRAME_WORDS; k++)
				snap[k] <= frame_words[k];
		end
	end

	// Byte position within the frame
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			word_idx <= 4'h0;
			byte_pos <= 3'h0;
		end
		else if (frame_load)
		begin
			word_idx <= 4'h0;
			byte_pos <= 3'h0;
		end
		else if (tx_load && (pointer == `DSP_LOC_FRAME)
			&& (word_idx != 4'(`DSP_FRAME_WORDS)))
		begin
			if (byte_pos == `DSP_POS_LAST)
			begin
				byte_pos <= 3'h0;
				word_idx <= word_idx + 4'h1;
			end
			else
				byte_pos <= byte_pos + 3'h1;
		end
	end

	assign cur_word = (word_idx < 4'(`DSP_FRAME_WORDS)) ? snap[word_idx] : 32'h0;
	assign cur_half = (byte_pos < `DSP_POS_LO) ? cur_word[31:16] : cur_word[15:0];

	dsp_crc8 u_crc (
		.data(cur_half),
		.crc(cur_crc)
	);

	// Upper half, checksum, lower half, checksum; zeros past byte 71
	always_comb
	begin
		frame_byte = 8'h00;
		if (word_idx < 4'(`DSP_FRAME_WORDS))
		begin
			case (byte_pos)
				3'h0: frame_byte = cur_word[31:24];
				3'h1: frame_byte = cur_word[23:16];
				3'h2: frame_byte = cur_crc;
				3'h3: frame_byte = cur_word[15:8];
				3'h4: frame_byte = cur_word[7:0];
				3'h5: frame_byte = cur_crc;
				default: frame_byte = 8'h00;
			endcase
		end
	end

	// Read data; write-only and undefined locations read as zero
	always_comb
	begin
		case (pointer)
			`DSP_LOC_FRAME: next_tx_byte = frame_byte;
			`DSP_LOC_POWER: next_tx_byte = {cfg.awake, 6'h00, new_data};
			`DSP_LOC_DEPTH: next_tx_byte = cfg.moving_average_depth;
			`DSP_LOC_INTERVAL: next_tx_byte = cfg.measure_interval;
			`DSP_LOC_PRERUN: next_tx_byte = cfg.fan_prerun_time;
			`DSP_LOC_PERIOD_HI: next_tx_byte = cfg.cleaning_period[15:8];
			`DSP_LOC_PERIOD_LO: next_tx_byte = cfg.cleaning_period[7:0];
			`DSP_LOC_DURATION: next_tx_byte = cfg.cleaning_duration;
			`DSP_LOC_FAN_SPEED: next_tx_byte = cfg.fan_speed_percent;
			default: next_tx_byte = 8'h00;
		endcase
	end

endmodule // dsp_i2c_port

`default_nettype wire

// *** dsp_i2c_port_asserts.sv ***
// Pin-level checks of the sensor command port.
// Assumes binding onto dsp_i2c_port; sees its ports only.
`include "dsp_map.svh"
`timescale 1ns/10ps
`default_nettype none

module dsp_i2c_port_asserts #(
	parameter int TICKS_PER_SEC = 20
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Bus and core side
	input wire logic scl_in,
	input wire logic sda_oe,
	input wire logic sda_out,
	input wire dsp_pkg::dsp_cfg_t cfg,
	input wire logic clean_start,
	input wire logic cleaning_busy,
	input wire logic soft_reset
);
	localparam dsp_pkg::dsp_cfg_t CFG_DEF = '{`DSP_AWAKE_DEF, `DSP_DEPTH_DEF,
		`DSP_INTERVAL_DEF, `DSP_PRERUN_DEF, `DSP_PERIOD_DEF, `DSP_DURATION_DEF, `DSP_SPEED_DEF};
	int busy_cnt;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	// Restarted by each trigger; soft reset ends the run and sets the limit back to the default duration
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			busy_cnt <= 0;
		else if (clean_start || soft_reset || !cleaning_busy)
			busy_cnt <= 0;
		else
			busy_cnt <= busy_cnt + 1;
	end
	sequence s_clean_go;
		clean_start ##[0:2] cleaning_busy;
	endsequence
	a_clean_pulse_once: assert property (clean_start |=> !clean_start)
		else $error("clean start wider than one cycle");
	a_clean_runs: assert property (clean_start && cfg.cleaning_duration != 8'h00 |-> s_clean_go)
		else $error("cleaning did not start");
	a_clean_bounded: assert property (busy_cnt <= cfg.cleaning_duration * TICKS_PER_SEC + 2)
		else $error("cleaning ran too long");
	a_reset_pulse_once: assert property (soft_reset |=> !soft_reset)
		else $error("soft reset wider than one cycle");
	a_reset_defaults: assert property (soft_reset |-> ##[1:2] cfg == CFG_DEF)
		else $error("settings not restored");
	a_reset_stops_clean: assert property (soft_reset |-> ##[1:2] !cleaning_busy)
		else $error("cleaning survived soft reset");
	a_depth_range: assert property (cfg.moving_average_depth inside {[8'h01:8'h3C]})
		else $error("depth out of range");
	a_interval_range: assert property (cfg.measure_interval <= 8'h3B)
		else $error("interval out of range");
	a_prerun_range: assert property (cfg.fan_prerun_time <= 8'h3B)
		else $error("pre-run out of range");
	a_speed_range: assert property (cfg.fan_speed_percent inside {[8'h3C:8'h64]})
		else $error("fan speed out of range");
	a_drive_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("data changed while clock high");
	a_pin_pulls_low: assert property (sda_oe |-> !sda_out)
		else $error("data pin driven high");
endmodule // dsp_i2c_port_asserts

`default_nettype wire

// *** dsp_i2c_master.sv ***
// Behavioural I2C master polling the sensor port.
// Assumes a pull-up on SDA; either side may pull it low.
`timescale 1ns/10ps
`default_nettype none

module dsp_i2c_master #(
	parameter int HALF_NS = 24
) (
	// Bus
	output var logic scl,
	output var logic sda_low,
	input wire logic sda
);
	// Idle bus: clock stands high, data released
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic m_start();
	begin
		#4 sda_low = 1'b0;
		#HALF_NS scl = 1'b1;
		#HALF_NS sda_low = 1'b1;
		#HALF_NS scl = 1'b0;
	end
	endtask
	task automatic m_stop();
	begin
		#4 sda_low = 1'b1;
		#HALF_NS scl = 1'b1;
		#HALF_NS sda_low = 1'b0;
		#HALF_NS;
	end
	endtask
	// Port never stretches, so the clock keeps its pace
	task automatic m_bit(input logic b, output logic r);
	begin
		#4 sda_low = !b;
		#(HALF_NS - 4) scl = 1'b1;
		#(HALF_NS / 2) r = sda;
		#(HALF_NS / 2) scl = 1'b0;
	end
	endtask
	task automatic m_byte(input logic [7:0] d, input logic nack, output logic [7:0] q,
		output logic ack_n);
	begin
		for (int i = 7; i >= 0; i--)
			m_bit(d[i], q[i]);
		m_bit(nack, ack_n);
	end
	endtask
endmodule // dsp_i2c_master

`default_nettype wire

// *** dsp_i2c_port_bench.sv ***
// Self-checking bench of the command port over I2C.
// Assumes dsp_i2c_master as bus partner and the checker bound below.
`timescale 1ns/10ps
`default_nettype none

module dsp_i2c_port_bench;
	localparam int TPS = 20;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic meas_valid = 1'b0;
	logic scl, sda_low, sda, sda_out, sda_oe, clean_start, cleaning_busy, soft_reset, ack_n;
	dsp_pkg::dsp_meas_t meas = '0;
	dsp_pkg::dsp_cfg_t cfg;
	int miscompares = 0;
	int n_tests = 0;
	int cyc = 0;
	int n_clean = 0;
	int n_sreset = 0;
	int i;
	logic [7:0] q;
	logic [31:0] wd;
	logic [7:0] exp_b [72];
	logic [7:0] dl [8] = '{8'h53, 8'h58, 8'h59, 8'h5A, 8'h5B, 8'h5C, 8'h63, 8'h50};
	logic [7:0] dv [8] = '{8'h0A, 8'h00, 8'h03, 8'hEC, 8'h40, 8'h0A, 8'h64, 8'h80};
	logic [7:0] wl [14] = '{8'h53, 8'h53, 8'h53, 8'h58, 8'h58, 8'h59, 8'h59, 8'h5C, 8'h5C,
		8'h63, 8'h63, 8'h5A, 8'h5B, 8'h55};
	logic [7:0] wv [14] = '{8'h3C, 8'h3D, 8'h00, 8'h3B, 8'h3C, 8'h3B, 8'h3C, 8'h3C, 8'h3D,
		8'h3B, 8'h3C, 8'h12, 8'h34, 8'h77};
	logic [7:0] we [14] = '{8'h3C, 8'h3C, 8'h3C, 8'h3B, 8'h3B, 8'h3B, 8'h3B, 8'h3C, 8'h3C,
		8'h64, 8'h3C, 8'h12, 8'h34, 8'h00};
	always #2.5 clk = !clk;
	// Open drain with pull-up; the port's driven level is what the pin shows
	assign sda = sda_low ? 1'b0 : (sda_oe ? sda_out : 1'b1);
	dsp_i2c_port #(.TICKS_PER_SEC(TPS)) dsp_i2c_port_i (.clk(clk), .rst_b(rst_b), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .meas(meas), .meas_valid(meas_valid),
		.cfg(cfg), .clean_start(clean_start), .cleaning_busy(cleaning_busy),
		.soft_reset(soft_reset));
	dsp_i2c_master dsp_i2c_master_i (.scl(scl), .sda_low(sda_low), .sda(sda));
	task automatic complete_run();
	begin
		$display("comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
	endtask
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		n_clean <= n_clean + clean_start;
		n_sreset <= n_sreset + soft_reset;
		if (cyc == 60000)
		begin
			miscompares++;
			complete_run();
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
	begin
		n_tests++;
		if (seen !== want)
		begin
			miscompares++;
			$display("[FAIL] %0t saw %h wanted %h", $time, seen, want);
		end
	end
	endtask
	function automatic logic [7:0] crc8(input logic [15:0] d);
		logic [7:0] c;
	begin
		c = 8'hFF;
		for (int k = 15; k >= 0; k--)
			c = (c[7] ^ d[k]) ? ((c << 1) ^ 8'h31) : (c << 1);
		return c;
	end
	endfunction
	task automatic point(input logic [7:0] loc);
	begin
		repeat (8) @(posedge clk);
		dsp_i2c_master_i.m_start();
		dsp_i2c_master_i.m_byte(8'h50, 1'b1, q, ack_n);
		dsp_i2c_master_i.m_byte(loc, 1'b1, q, ack_n);
	end
	endtask
	task automatic reg_wr(input logic [7:0] loc, input logic [7:0] val);
	begin
		point(loc);
		dsp_i2c_master_i.m_byte(val, 1'b1, q, ack_n);
		dsp_i2c_master_i.m_stop();
	end
	endtask
	task automatic reg_rd(input logic [7:0] loc, input logic [7:0] want);
	begin
		point(loc);
		dsp_i2c_master_i.m_start();
		dsp_i2c_master_i.m_byte(8'h51, 1'b1, q, ack_n);
		dsp_i2c_master_i.m_byte(8'hFF, 1'b1, q, ack_n);
		dsp_i2c_master_i.m_stop();
		check(q, want);
	end
	endtask
	initial
	begin
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		for (i = 0; i < 8; i++)
			reg_rd(dl[i], dv[i]);
		for (i = 0; i < 14; i++)
		begin
			reg_wr(wl[i], wv[i]);
			reg_rd(wl[i], we[i]);
		end
		reg_wr(8'h50, 8'h00);
		check(cfg.awake, 1'b0);
		@(posedge clk);
		meas_valid <= 1'b1;
		@(posedge clk);
		meas_valid <= 1'b0;
		reg_rd(8'h50, 8'h01);
		reg_wr(8'h50, 8'h80);
		for (i = 0; i < 11; i++)
			meas.value[i] <= {8'(i), 8'hC3, 8'(i + 64), 8'h0F};
		meas.flags <= 3'h5;
		@(posedge clk);
		for (i = 0; i < 12; i++)
		begin
			wd = (i < 5) ? meas.value[i] : (i == 5) ? {29'h0, meas.flags} : meas.value[i - 1];
			exp_b[6 * i] = wd[31:24];
			exp_b[6 * i + 1] = wd[23:16];
			exp_b[6 * i + 2] = crc8(wd[31:16]);
			exp_b[6 * i + 3] = wd[15:8];
			exp_b[6 * i + 4] = wd[7:0];
			exp_b[6 * i + 5] = crc8(wd[15:0]);
		end
		point(8'h00);
		dsp_i2c_master_i.m_start();
		dsp_i2c_master_i.m_byte(8'h51, 1'b1, q, ack_n);
		for (i = 0; i < 72; i++)
		begin
			dsp_i2c_master_i.m_byte(8'hFF, i == 71, q, ack_n);
			check(q, exp_b[i]);
		end
		dsp_i2c_master_i.m_stop();
		reg_rd(8'h50, 8'h80);
		reg_wr(8'h51, 8'h00);
		check(8'(n_clean), 8'h00);
		reg_wr(8'h51, 8'h01);
		check(8'(n_clean), 8'h01);
		check(cleaning_busy, 1'b1);
		for (i = 0; i < 1400 && cleaning_busy; i++)
			@(posedge clk);
		check(i > 1100 && !cleaning_busy, 1'b1);
		reg_wr(8'h51, 8'h01);
		reg_wr(8'h52, 8'h80);
		check(8'(n_sreset), 8'h00);
		reg_wr(8'h52, 8'h81);
		check(8'(n_sreset), 8'h01);
		check(cleaning_busy, 1'b0);
		for (i = 0; i < 8; i++)
			reg_rd(dl[i], dv[i]);
		complete_run();
	end
endmodule // dsp_i2c_port_bench

bind dsp_i2c_port dsp_i2c_port_asserts #(.TICKS_PER_SEC(TICKS_PER_SEC)) dsp_i2c_port_asserts_i (
	.clk(clk), .rst_b(rst_b), .scl_in(scl_in), .sda_oe(sda_oe), .sda_out(sda_out), .cfg(cfg),
	.clean_start(clean_start), .cleaning_busy(cleaning_busy), .soft_reset(soft_reset));

`default_nettype wire
